// ===== verilog/tx_dma_write.v
// Transmit DMA write channel: request/acknowledge handshake toward an
// external DMA controller, strobe capture into a 4-word FIFO, config reg.
// Assumes strobe and acknowledge pins are asynchronous to core_clk_i and
// the data bus is stable while a strobe is low.
//
// Function
// - Rising edge of soft reset bit resets the write channel.
// - Enable bit, default 0, switches the write interface on or off.
// - Request only while the transmit buffer has room for a message.
// - Data flows only from external memory into transmit buffers.
// - A transfer cycle starts with the request output driven low.
// - Style bit 0 is direction plus read strobe, 1 is write strobe.
// - Three-bit channel select; code 000 is channel 0, 1xx reserved.
`timescale 1ns/1ps
`include "tx_dma_write_map.vh"
module tx_dma_write #(
    parameter DATA_W = 8,
    parameter FIFO_DEPTH = 4,
    parameter FIFO_AW = 2,
    parameter MY_CHANNEL = 3'h0
) (
    // Clock and reset
    input wire core_clk_i,
    input wire resetn_i,
    // Register port
    input wire [11:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    // DMA pins from the external controller
    output reg transfer_request_n_o,
    input wire transfer_acknowledge_n_i,
    input wire bus_wr_n_i,
    input wire bus_rd_n_i,
    input wire [DATA_W-1:0] bus_data_i,
    // Transmit buffer side
    input wire buffer_room_i,
    output reg buf_valid_o,
    input wire buf_ready_i,
    output reg [DATA_W-1:0] buf_data_o
);
    // Request state machine
    localparam ST_IDLE = 2'b00;
    localparam ST_REQ = 2'b01;
    localparam ST_XFER = 2'b10;

    reg [7:0] cfg_q;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg chan_rst_q;
    reg [`TDW_SYNC_LEN-1:0] ack_sync_q;
    reg [`TDW_SYNC_LEN-1:0] wr_sync_q;
    reg [`TDW_SYNC_LEN-1:0] rd_sync_q;
    reg ack_n_q;
    reg wr_n_q;
    reg rd_n_q;
    reg [DATA_W-1:0] data_q;
    reg strobe_q;
    wire enable;
    wire style_wr;
    wire chan_ok;
    wire run;
    wire rst_rise;
    wire strobe_fall;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [DATA_W-1:0] fifo_out_data;
    wire [FIFO_AW:0] fifo_count;
    wire drain_ready;

    assign enable = cfg_q[`TDW_ENB_BIT];
    assign style_wr = cfg_q[`TDW_STYLE_BIT];
    // Reserved codes 1xx never match, so the channel stays idle
    assign chan_ok = (cfg_q[`TDW_SEL_HI:`TDW_SEL_LO] == MY_CHANNEL) &&
        !cfg_q[`TDW_SEL_HI];
    // Soft reset fires on a 0 to 1 write of the reset bit
    assign rst_rise = reg_wr_i && (reg_addr_i == `TDW_CFG_ADDR) &&
        reg_wdata_i[`TDW_RST_BIT] && !cfg_q[`TDW_RST_BIT];
    assign run = enable && chan_ok && !chan_rst_q;

    // Config register; reserved bits stay zero
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_q <= `TDW_CFG_RESET;
        end else if (reg_wr_i && reg_addr_i == `TDW_CFG_ADDR) begin
            cfg_q <= reg_wdata_i & `TDW_CFG_MASK;
        end
    end

    // One-cycle channel reset pulse, kept apart from the global reset
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i)
            chan_rst_q <= 1'b0;
        else
            chan_rst_q <= rst_rise;
    end

    // Register read data, valid the cycle after the read strobe
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `TDW_CFG_ADDR: reg_rdata_o <= cfg_q;
                `TDW_STAT_ADDR: reg_rdata_o <= {2'h0, fifo_count,
                    !transfer_request_n_o, state_q};
                default: reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // Three-flop filters on the pins; a level is taken once the last
    // two stages agree, which rejects a single-cycle glitch
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_sync_q <= {`TDW_SYNC_LEN{1'b1}};
            wr_sync_q <= {`TDW_SYNC_LEN{1'b1}};
            rd_sync_q <= {`TDW_SYNC_LEN{1'b1}};
            ack_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            rd_n_q <= 1'b1;
        end else begin
            ack_sync_q <= {ack_sync_q[1:0], transfer_acknowledge_n_i};
            wr_sync_q <= {wr_sync_q[1:0], bus_wr_n_i};
            rd_sync_q <= {rd_sync_q[1:0], bus_rd_n_i};
            if (ack_sync_q[1] == ack_sync_q[2])
                ack_n_q <= ack_sync_q[2];
            if (wr_sync_q[1] == wr_sync_q[2])
                wr_n_q <= wr_sync_q[2];
            if (rd_sync_q[1] == rd_sync_q[2])
                rd_n_q <= rd_sync_q[2];
        end
    end

    // Strobe selected by the style bit
    // Write strobe style takes words on write low
    // Direction style takes words on read low with write high
    wire strobe_n = style_wr ? (wr_n_q & rd_n_q) | wr_n_q :
        rd_n_q | !wr_n_q;
    assign strobe_fall = !strobe_n && strobe_q;

    // Capture data when the strobe is first seen low; the bus has been
    // stable for the filter delay by then
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            strobe_q <= 1'b1;
            data_q <= {DATA_W{1'b0}};
        end else begin
            strobe_q <= strobe_n;
            if (strobe_fall)
                data_q <= bus_data_i;
        end
    end

    // Handshake: request while room exists, transfer after acknowledge
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (run && buffer_room_i && fifo_in_ready)
                state_d = ST_REQ;
            ST_REQ: begin
                if (!run || !buffer_room_i)
                    state_d = ST_IDLE;
                else if (!ack_n_q)
                    state_d = ST_XFER;
            end
            ST_XFER: begin
                if (!run || ack_n_q)
                    state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    // Words pushed only during an acknowledged transfer, inbound only
    wire push = (state_q == ST_XFER) && run && !ack_n_q &&
        strobe_fall;

    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q <= ST_IDLE;
            transfer_request_n_o <= 1'b1;
        end else begin
            state_q <= state_d;
            // Request low starts the cycle; dropped when the FIFO fills
            // so the controller pauses instead of overrunning it
            transfer_request_n_o <= !(run && buffer_room_i &&
                fifo_in_ready && state_d != ST_IDLE);
        end
    end

    // Data pipe into the transmit buffer through the FIFO; the push sits
    // one cycle behind capture so the stored word is the captured one
    reg push_q;
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i)
            push_q <= 1'b0;
        else
            push_q <= push && !chan_rst_q;
    end

    tdw_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .flush_i(chan_rst_q),
        .in_valid_i(push_q),
        .in_ready_o(fifo_in_ready),
        .in_data_i(data_q),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(drain_ready),
        .out_data_o(fifo_out_data),
        .count_o(fifo_count)
    );

    // Registered output stage; takes a word when empty or being taken
    assign drain_ready = !buf_valid_o || buf_ready_i;
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            buf_valid_o <= 1'b0;
            buf_data_o <= {DATA_W{1'b0}};
        end else if (chan_rst_q) begin
            buf_valid_o <= 1'b0;
        end else if (drain_ready) begin
            buf_valid_o <= fifo_out_valid;
            if (fifo_out_valid)
                buf_data_o <= fifo_out_data;
        end
    end
endmodule // tx_dma_write

// ===== shared/tx_dma_write_map.vh
// Register map and field layout of the transmit DMA write channel.
// Assumes the includer uses these as plain constants; definitions only.
`ifndef TX_DMA_WRITE_MAP_VH
`define TX_DMA_WRITE_MAP_VH

// Register offset
`define TDW_CFG_ADDR 12'h0118
// Status register holding request, fifo and channel state
`define TDW_STAT_ADDR 12'h0119
// Config field positions
`define TDW_RST_BIT 7
`define TDW_ENB_BIT 6
`define TDW_STYLE_BIT 5
`define TDW_SEL_HI 2
`define TDW_SEL_LO 0
// Config reset value
`define TDW_CFG_RESET 8'h00
// Writable bits mask: bits 4 and 3 are reserved
`define TDW_CFG_MASK 8'hE7
// Pin filter depth: three flops, last two agree
`define TDW_SYNC_LEN 3

`endif

// ===== verilog/tdw_fifo.v
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module tdw_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // Clock and reset
    input wire core_clk_i,
    input wire resetn_i,
    input wire flush_i,
    // Fill side
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    // Drain side
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o,
    // Occupancy
    output wire [AW:0] count_o
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;

    assign in_ready_o = (cnt_q != DEPTH[AW:0]);
    assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
    assign out_data_o = mem_q[rd_q];
    assign count_o = cnt_q;
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    // Pointers and count; flush drops everything held
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else if (flush_i) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                    wr_q + 1'b1;
            if (pop)
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                    rd_q + 1'b1;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end

    // Storage needs no reset; valid is tracked by the count
    always @(posedge core_clk_i) begin
        if (push)
            mem_q[wr_q] <= in_data_i;
    end
endmodule // tdw_fifo

// ===== bench/tx_dma_write_monitor.sv
// Checker for the transmit DMA write channel ports.
// Assumes it is bound to tx_dma_write and sees only its ports.
`timescale 1ns/1ps
`include "tx_dma_write_map.vh"
module tx_dma_write_monitor #(
    parameter DATA_W = 8
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic resetn_i,
    // Register port
    input wire logic [11:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // DMA pins
    input wire logic transfer_request_n_o,
    input wire logic transfer_acknowledge_n_i,
    input wire logic bus_wr_n_i,
    input wire logic bus_rd_n_i,
    input wire logic [DATA_W-1:0] bus_data_i,
    // Buffer side
    input wire logic buffer_room_i,
    input wire logic buf_valid_o,
    input wire logic buf_ready_i,
    input wire logic [DATA_W-1:0] buf_data_o
);
    logic [7:0] cfg_q;
    logic [1:0] wr_sh_q;
    wire cfg_wr = reg_wr_i && reg_addr_i == `TDW_CFG_ADDR;
    // Shadow config; write history masks the soft reset flush window
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_q <= `TDW_CFG_RESET;
            wr_sh_q <= 2'h0;
        end else begin
            wr_sh_q <= {wr_sh_q[0], reg_wr_i};
            if (cfg_wr)
                cfg_q <= reg_wdata_i & `TDW_CFG_MASK;
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    a_cfg_read_back: assert property (
        $past(reg_rd_i && reg_addr_i == `TDW_CFG_ADDR)
        |-> reg_rdata_o == $past(cfg_q)) else $error("config readback");
    a_unmapped_zero: assert property (
        $past(reg_rd_i && reg_addr_i > 12'h0119) |-> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_disabled_quiet: assert property (
        !cfg_q[6] [*3] |-> transfer_request_n_o) else $error("req off");
    a_room_gates_req: assert property (
        !buffer_room_i [*3] |-> transfer_request_n_o) else $error("no room");
    a_reserved_sel: assert property (
        cfg_q[2] [*3] |-> transfer_request_n_o) else $error("reserved");
    a_req_cause: assert property (
        $fell(transfer_request_n_o)
        |-> $past(cfg_q[6] && cfg_q[2:0] == 3'h0 && buffer_room_i))
        else $error("request without cause");
    a_valid_holds: assert property (
        buf_valid_o && !buf_ready_i && !reg_wr_i && wr_sh_q == 2'h0
        |=> buf_valid_o && $stable(buf_data_o)) else $error("word lost");
    a_soft_reset: assert property (
        cfg_wr && reg_wdata_i[7] && !cfg_q[7]
        |-> ##[1:3] transfer_request_n_o && !buf_valid_o)
        else $error("soft reset");
    c_request: cover property ($fell(transfer_request_n_o));
    c_word_out: cover property (buf_valid_o && buf_ready_i);
    c_soft_reset: cover property (cfg_wr && reg_wdata_i[7]);
endmodule // tx_dma_write_monitor
bind tx_dma_write tx_dma_write_monitor #(.DATA_W(DATA_W)) u_mon (.*);

// ===== bench/dma_ctrl_model.sv
// Behavioural external DMA controller driving the write channel pins.
// Assumes the bench calls xfer once per word and waits for its end.
`timescale 1ns/1ps
module dma_ctrl_model (
    // Clock
    input wire logic core_clk_i,
    // Pins toward the channel
    input wire logic transfer_request_n_i,
    output logic ack_n_o = 1'b1,
    output logic wr_n_o = 1'b1,
    output logic rd_n_o = 1'b1,
    output logic [7:0] data_o = 8'h00
);
    // One word per handshake; the channel sees a strobe four clocks
    // late and takes the bus one clock after, so hold it six clocks
    task automatic xfer(input logic [7:0] w, input logic sty,
                        output bit ok);
        ok = 0;
        for (int n = 0; n < 300 && transfer_request_n_i !== 1'b0; n++)
            @(negedge core_clk_i);
        if (transfer_request_n_i !== 1'b0)
            return;
        @(posedge core_clk_i);
        ack_n_o <= 1'b0;
        repeat (6) @(posedge core_clk_i);
        data_o <= w;
        wr_n_o <= !sty;
        rd_n_o <= sty;
        repeat (6) @(posedge core_clk_i);
        wr_n_o <= 1'b1;
        rd_n_o <= 1'b1;
        data_o <= ~w; // Stale word must not look valid
        repeat (4) @(posedge core_clk_i);
        ack_n_o <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        ok = 1;
    endtask
endmodule // dma_ctrl_model

// ===== bench/tx_dma_write_tb.sv
// Self-checking bench for the transmit DMA write channel.
// Assumes the checker is bound in and the controller model sits beside.
`timescale 1ns/1ps
`include "tx_dma_write_map.vh"
module tx_dma_write_tb;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic room = 1'b1, rdy = 1'b0, hold = 1'b1;
    logic [11:0] addr = 12'h0000;
    logic [7:0] wdat = 8'h00, w;
    logic [7:0] exp_q[$];
    wire [7:0] rdat, bdat, pdat;
    wire req_n, ack_n, wr_n, rd_n, bval;
    int error_cnt = 0, compares = 0, cyc = 0;
    bit ok;
    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end
    tx_dma_write dut (.core_clk_i(clk), .resetn_i(rst_n),
        .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdat), .transfer_request_n_o(req_n),
        .transfer_acknowledge_n_i(ack_n), .bus_wr_n_i(wr_n),
        .bus_rd_n_i(rd_n), .bus_data_i(pdat), .buffer_room_i(room),
        .buf_valid_o(bval), .buf_ready_i(rdy), .buf_data_o(bdat));
    dma_ctrl_model u_ctl (.core_clk_i(clk), .transfer_request_n_i(req_n),
        .ack_n_o(ack_n), .wr_n_o(wr_n), .rd_n_o(rd_n), .data_o(pdat));
    task automatic tally_and_finish();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %h not %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wreg(input logic [7:0] d);
        @(posedge clk);
        addr <= `TDW_CFG_ADDR;
        wdat <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdat, e);
    endtask
    task automatic send(input logic sty);
        w = $urandom;
        exp_q.push_back(w);
        u_ctl.xfer(w, sty, ok);
        chk({7'h00, ok}, 8'h01);
    endtask
    task automatic drain();
        for (int n = 0; n < 500 && exp_q.size() > 0; n++)
            @(posedge clk);
        chk(8'(exp_q.size()), 8'h00);
    endtask
    // Reference model: words leave in arrival order; cycle ceiling
    always @(negedge clk) begin
        if (rst_n && bval && rdy)
            chk(bdat, exp_q.size() ? exp_q.pop_front() : ~bdat);
    end
    always @(posedge clk) begin
        rdy <= hold ? 1'b0 : 1'($urandom % 2);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(4726));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rreg(`TDW_CFG_ADDR, 8'h00);
        rreg(`TDW_STAT_ADDR, 8'h00);
        rreg(12'h0200, 8'h00);
        wreg(8'hff);
        rreg(`TDW_CFG_ADDR, 8'he7);
        wt(8);
        chk({7'h00, req_n}, 8'h01);
        wreg(8'h20);
        wt(8);
        chk({7'h00, req_n}, 8'h01);
        $display("test done: registers and idle");
        @(posedge clk) room <= 1'b0;
        wreg(8'h60);
        wt(8);
        chk({7'h00, req_n}, 8'h01);
        @(posedge clk) room <= 1'b1;
        wt(4);
        chk({7'h00, req_n}, 8'h00);
        hold <= 1'b0;
        repeat (3) send(1'b1);
        wreg(8'h40);
        repeat (3) send(1'b0);
        drain();
        $display("test done: both strobe styles");
        hold <= 1'b1;
        // One word waits at the output, four fill the FIFO
        repeat (5) send(1'b0);
        wt(8);
        chk({7'h00, req_n}, 8'h01);
        rreg(`TDW_STAT_ADDR, 8'h20);
        hold <= 1'b0;
        drain();
        $display("test done: buffer full");
        hold <= 1'b1;
        repeat (2) send(1'b0);
        wreg(8'hc0);
        wt(3);
        chk({7'h00, bval}, 8'h00);
        exp_q.delete();
        wreg(8'h40);
        hold <= 1'b0;
        send(1'b0);
        drain();
        $display("test done: soft reset");
        tally_and_finish();
    end
endmodule // tx_dma_write_tb
